// >>> flow_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module flow_ctrl (
    input wire logic clk_sys, // 20 MHz core clock
    input wire logic reset_n, // Async reset, active low
    input wire logic issue, // Instruction presented
    output logic ready, // Block can take an instruction
    input wire logic [31:0] instr, // Instruction word
    input wire logic [flow_ctrl_pkg::XLEN-1:0] pc, // Address of instruction
    input wire logic [flow_ctrl_pkg::XLEN-1:0] src_a, // Value of reg field 5..0
    input wire logic [flow_ctrl_pkg::XLEN-1:0] src_b, // Value of reg field 11..6
    input wire logic [flow_ctrl_pkg::XLEN-1:0] src_c, // Value of reg field 17..12
    output logic [flow_ctrl_pkg::XLEN-1:0] tlb_addr, // Address probed in ITLB
    input wire logic tlb_hit, // ITLB holds tlb_addr
    input wire logic target_buffered, // Target already in buffer
    input wire logic fetch_done, // Slow target fetch finished
    input wire logic [flow_ctrl_pkg::XLEN-1:0] service_base, // Supervisor entry base
    input wire logic [15:0] service_limit, // Implemented services
    output flow_ctrl_pkg::result_t result // Registered outcome, one cycle
);
    import flow_ctrl_pkg::*;

    typedef enum logic {IDLE, WAIT_FETCH} state_t;
    state_t state;
    result_t next_result;
    result_t held;
    logic [7:0] opc;
    logic take;
    logic go_slow;

    function automatic logic cond_true(input cond_t c, input logic [XLEN-1:0] v);
        case (c)
            COND_ZERO: cond_true = (v == '0);
            COND_MSB: cond_true = v[XLEN-1];
            COND_LSB0: cond_true = !v[0];
            COND_NZ: cond_true = (v != '0);
            COND_NMSB: cond_true = !v[XLEN-1];
            COND_LSB1: cond_true = v[0];
            default: cond_true = 1'b0;
        endcase
    endfunction : cond_true

    assign opc = instr[31:OPC_LSB];
    assign ready = (state == IDLE);

    // Loop entry probes its own fall-through address, jumps their target
    always_comb begin
        if (opc == RELATIVE_ADDRESS_LOAD_OPCODE) begin
            tlb_addr = pc + LINK_STEP;
        end else begin
            tlb_addr = src_b;
        end
    end

    always_comb begin
        cond_t cc;
        cc = cond_t'(instr[NEG_BIT:COND_LSB]);
        next_result = '0;
        take = 1'b0;
        go_slow = 1'b0;
        // Hint bits 23..22 and bit 18 are never looked at by the register jump
        case (opc)
            NO_OPERATION_OPCODE: begin
                next_result.nop_done = 1'b1;
            end
            REGISTER_BRANCH_OPCODE: begin
                // No suffix assembles as zero-test on r0, always true
                if (instr[17:12] == 6'd0 && cc == COND_ZERO) begin
                    take = 1'b1;
                end else if (cc == COND_BAD1 || cc == COND_BAD5) begin
                    next_result.invalid = 1'b1;
                end else begin
                    take = cond_true(cc, src_c);
                end
                if (take) begin
                    if (src_b[1:0] != 2'b00) begin
                        next_result.align_fault = 1'b1;
                    end else if (!tlb_hit) begin
                        next_result.page_fault = 1'b1;
                    end else begin
                        next_result.pc_we = 1'b1;
                        next_result.pc_next = src_b;
                        next_result.reg_idx = instr[5:0];
                        next_result.reg_data = pc + LINK_STEP;
                        next_result.reg_we = (instr[5:0] != 6'd0);
                        go_slow = !target_buffered;
                    end
                end
            end
            RELATIVE_ADDRESS_LOAD_OPCODE: begin
                if (!instr[DATA_FLAG_BIT] && instr[23:6] == 18'd0) begin
                    next_result.reg_we = 1'b1;
                    next_result.reg_idx = instr[5:0];
                    next_result.reg_data = pc + LINK_STEP;
                    next_result.page_fault = !tlb_hit;
                end else begin
                    next_result.invalid = 1'b1;
                end
            end
            COUNTDOWN_BRANCH_OPCODE: begin
                // Decrement and test of the old value share one cycle
                next_result.reg_we = 1'b1;
                next_result.reg_idx = instr[5:0];
                next_result.reg_data = src_a - 64'h0000_0000_0000_0001;
                next_result.pc_we = (src_a != '0);
                next_result.pc_next = src_b;
            end
            SUPERVISOR_CALL_OPCODE: begin
                next_result.supervisor = 1'b1;
                next_result.slice_end = instr[TRAP_BIT];
                next_result.reg_we = 1'b1;
                next_result.reg_idx = instr[5:0];
                next_result.reg_data = '0;
                next_result.service_addr = service_base
                    + (XLEN'(instr[21:IMM_LSB]) << SVC_SHIFT);
                next_result.service_trap = (instr[21:IMM_LSB] > service_limit);
                next_result.pc_we = !next_result.service_trap;
                next_result.pc_next = next_result.service_addr;
            end
            default: begin
                next_result = '0;
            end
        endcase
    end

    // Unbuffered target: hold the outcome until the fetch completes
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= IDLE;
        end else begin
            case (state)
                IDLE: begin
                    if (issue && go_slow) begin
                        state <= WAIT_FETCH;
                    end
                end
                WAIT_FETCH: begin
                    if (fetch_done) begin
                        state <= IDLE;
                    end
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            held <= '0;
        end else if (ready && issue && go_slow) begin
            held <= next_result;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            result <= '0;
        end else if (state == WAIT_FETCH) begin
            result <= fetch_done ? held : '0;
        end else if (issue && !go_slow) begin
            result <= next_result;
        end else begin
            result <= '0;
        end
    end

    AST_NOP_QUIET: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == NO_OPERATION_OPCODE)
        |=> (result.nop_done && !result.reg_we && !result.pc_we))
        else $error("nop changed state");

    AST_LINK_VALUE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == REGISTER_BRANCH_OPCODE && target_buffered
         && next_result.pc_we)
        |=> (result.pc_next == $past(src_b) && result.reg_data == $past(pc) + 64'd4))
        else $error("jump link or target wrong");

    AST_ZERO_LINK: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (result.pc_we && result.reg_idx == 6'd0 && !result.supervisor)
        |-> !result.reg_we)
        else $error("link written to register zero");

    AST_ALIGN_FIRST: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == REGISTER_BRANCH_OPCODE && take && src_b[1:0] != 2'b00)
        |=> (result.align_fault && !result.page_fault && !result.pc_we))
        else $error("alignment fault not first");

    AST_PAGE_FAULT: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == REGISTER_BRANCH_OPCODE && take
         && src_b[1:0] == 2'b00 && !tlb_hit)
        |=> result.page_fault)
        else $error("missing page fault");

    AST_NEGATE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == REGISTER_BRANCH_OPCODE && instr[17:12] != 6'd0
         && instr[20:19] != 2'b01)
        |-> (take == (cond_true(cond_t'({1'b0, instr[20:19]}), src_c) ^ instr[NEG_BIT])))
        else $error("negation flag ignored");

    AST_LOOP_STEP: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == COUNTDOWN_BRANCH_OPCODE)
        |=> (result.reg_data == $past(src_a) - 64'd1
             && result.pc_we == ($past(src_a) != 64'd0)))
        else $error("loop step wrong");

    AST_SVC_TRAP: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == SUPERVISOR_CALL_OPCODE)
        |=> (result.supervisor && result.reg_data == 64'd0
             && result.service_trap == ($past(instr[21:6]) > $past(service_limit))))
        else $error("supervisor call outcome wrong");

    AST_BAD_COND: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == REGISTER_BRANCH_OPCODE && instr[20:19] == 2'b01)
        |=> (result.invalid && !result.pc_we))
        else $error("unassigned condition accepted");

    AST_SLOW_JUMP: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state == WAIT_FETCH && fetch_done) |=> (state == IDLE && result.pc_we))
        else $error("slow jump not released");

    AST_NOP_NO_FAULT: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == NO_OPERATION_OPCODE)
        |=> (!result.align_fault && !result.page_fault && !result.invalid
             && !result.supervisor && !result.slice_end))
        else $error("nop raised an event");

    // Unconditional form must not depend on whatever the condition operand shows
    AST_ALWAYS_TAKEN: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == REGISTER_BRANCH_OPCODE && instr[21:19] == 3'b000
         && instr[17:12] == 6'd0)
        |=> (result.pc_we || result.align_fault || result.page_fault || !ready))
        else $error("unconditional jump skipped");

    AST_PAGE_NO_LINK: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == REGISTER_BRANCH_OPCODE && take
         && src_b[1:0] == 2'b00 && !tlb_hit)
        |=> (!result.pc_we && !result.reg_we))
        else $error("faulting jump still linked");

    AST_NEG_SKIP: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == REGISTER_BRANCH_OPCODE && instr[21:19] == 3'b100
         && src_c == 64'd0)
        |=> (ready && !result.pc_we && !result.align_fault && !result.page_fault))
        else $error("nonzero test taken on zero");

    AST_ENTRY_LINK: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == RELATIVE_ADDRESS_LOAD_OPCODE && instr[23:6] == 18'd0)
        |=> (result.reg_we && result.reg_idx == $past(instr[5:0])
             && result.reg_data == $past(pc) + 64'd4
             && result.page_fault == !$past(tlb_hit)))
        else $error("loop entry outcome wrong");

    AST_ENTRY_DECODE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == RELATIVE_ADDRESS_LOAD_OPCODE && instr[23:6] != 18'd0)
        |=> (result.invalid && !result.reg_we))
        else $error("malformed loop entry accepted");

    AST_LOOP_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == COUNTDOWN_BRANCH_OPCODE)
        |=> (ready && result.reg_we && result.reg_idx == $past(instr[5:0])))
        else $error("loop took more than one cycle");

    AST_LOOP_LAST: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == COUNTDOWN_BRANCH_OPCODE && src_a == 64'd0)
        |=> (!result.pc_we && result.reg_data == 64'hFFFF_FFFF_FFFF_FFFF))
        else $error("expired loop not ending at minus one");

    AST_SVC_MODE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == SUPERVISOR_CALL_OPCODE)
        |=> (result.supervisor && result.pc_we == !result.service_trap))
        else $error("supervisor entry wrong");

    AST_SLICE_END: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == SUPERVISOR_CALL_OPCODE)
        |=> (result.slice_end == $past(instr[TRAP_BIT])))
        else $error("trap flag not followed");

    AST_SVC_CLEAR: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == SUPERVISOR_CALL_OPCODE)
        |=> (result.reg_we && result.reg_idx == $past(instr[5:0])))
        else $error("call operand not cleared");

    AST_SVC_ENTRY: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == SUPERVISOR_CALL_OPCODE)
        |=> (result.service_addr
             == $past(service_base) + {42'd0, $past(instr[21:6]), 6'd0}))
        else $error("service entry address wrong");

    // A missed target must park the block instead of answering early
    AST_SLOW_STALL: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ready && issue && opc == REGISTER_BRANCH_OPCODE && !target_buffered
         && next_result.pc_we)
        |=> (!ready && result == '0))
        else $error("unbuffered jump did not stall");

    AST_STALL_QUIET: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state == WAIT_FETCH && !fetch_done) |=> (state == WAIT_FETCH && result == '0))
        else $error("output during fetch stall");
endmodule : flow_ctrl
`default_nettype wire

// >>> flow_ctrl_pkg.sv
package flow_ctrl_pkg;
    localparam int XLEN = 64;
    localparam logic [7:0] NO_OPERATION_OPCODE = 8'h0_1;
    localparam logic [7:0] REGISTER_BRANCH_OPCODE = 8'h0_2;
    localparam logic [7:0] COUNTDOWN_BRANCH_OPCODE = 8'h0_3;
    localparam logic [7:0] SUPERVISOR_CALL_OPCODE = 8'h0_4;
    localparam logic [7:0] RELATIVE_ADDRESS_LOAD_OPCODE = 8'h0_5;
    localparam int OPC_LSB = 24;
    localparam int NEG_BIT = 21;
    localparam int COND_LSB = 19;
    localparam int TRAP_BIT = 23;
    localparam int IMM_LSB = 6;
    localparam int DATA_FLAG_BIT = 23;
    localparam int SVC_SHIFT = 6;
    localparam logic [XLEN-1:0] LINK_STEP = 64'h0000_0000_0000_0004;
    localparam int JUMP_BUFFERED_CYCLES = 1;

    typedef enum logic [2:0] {
        COND_ZERO = 3'h0, COND_BAD1 = 3'h1, COND_MSB = 3'h2, COND_LSB0 = 3'h3,
        COND_NZ = 3'h4, COND_BAD5 = 3'h5, COND_NMSB = 3'h6, COND_LSB1 = 3'h7
    } cond_t;

    typedef struct packed {
        logic reg_we;
        logic [5:0] reg_idx;
        logic [XLEN-1:0] reg_data;
        logic pc_we;
        logic [XLEN-1:0] pc_next;
        logic align_fault;
        logic page_fault;
        logic invalid;
        logic supervisor;
        logic [XLEN-1:0] service_addr;
        logic service_trap;
        logic slice_end;
        logic nop_done;
    } result_t;
endpackage : flow_ctrl_pkg

// >>> fetch_model.sv
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
    input wire logic clk_sys, // Core clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [flow_ctrl_pkg::XLEN-1:0] tlb_addr, // Probed address
    input wire logic ready, // Low while a fetch is awaited
    input wire logic slow, // Targets miss the buffer
    output logic tlb_hit, // Address is mapped
    output logic target_buffered, // Target already buffered
    output var logic fetch_done // One-cycle end of fetch
);
    logic [2:0] wait_cnt;
    // Only the low 64 KiB is mapped, so higher targets must page-fault
    assign tlb_hit = tlb_addr < 64'h0000_0000_0001_0000;
    assign target_buffered = !slow;
    // The fetch ends five cycles into the stall, never at once
    always_ff @(negedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wait_cnt <= 3'h0;
            fetch_done <= 1'b0;
        end else begin
            fetch_done <= !ready && wait_cnt == 3'h4;
            wait_cnt <= ready ? 3'h0 : wait_cnt + 3'h1;
        end
    end
endmodule : fetch_model
`default_nettype wire

// >>> test_branch_loop_syscall_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_branch_loop_syscall_control;
    import flow_ctrl_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic issue = 1'b0;
    logic slow = 1'b0;
    logic [31:0] instr = 32'h0000_0000;
    logic [XLEN-1:0] pc = 64'h0000_0000_0000_1000;
    logic [XLEN-1:0] src_a = '0, src_b = '0, src_c = '0, cnt;
    logic [XLEN-1:0] service_base = 64'h0000_0000_0000_8000;
    logic [15:0] service_limit = 16'h0000;
    logic [XLEN-1:0] tlb_addr;
    logic ready, tlb_hit, target_buffered, fetch_done;
    logic [XLEN-1:0] vals [4] = '{64'h0, 64'h1, 64'h8000_0000_0000_0000, 64'h2};
    result_t result, got, exp;
    int n_fail = 0, comparisons = 0, cyc = 0, iters;

    flow_ctrl i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .issue(issue), .ready(ready),
        .instr(instr), .pc(pc), .src_a(src_a), .src_b(src_b), .src_c(src_c),
        .tlb_addr(tlb_addr), .tlb_hit(tlb_hit), .target_buffered(target_buffered),
        .fetch_done(fetch_done), .service_base(service_base),
        .service_limit(service_limit), .result(result));
    fetch_model i_far (.clk_sys(clk_sys), .reset_n(reset_n), .tlb_addr(tlb_addr),
        .ready(ready), .slow(slow), .tlb_hit(tlb_hit), .target_buffered(target_buffered),
        .fetch_done(fetch_done));

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    task give_verdict;
        $display("fails=%0d comparisons=%0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            $display("MISMATCH %0t timeout", $time);
            give_verdict();
        end
    end

    // Fields behind a low enable are don't-care
    function automatic result_t norm(result_t r);
        if (!r.reg_we) begin
            r.reg_idx = '0;
            r.reg_data = '0;
        end
        if (!r.pc_we) r.pc_next = '0;
        if (!r.supervisor) r.service_addr = '0;
        return r;
    endfunction : norm

    task chk_res(input result_t e, input string what);
        comparisons++;
        if (norm(got) !== norm(e)) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, e);
        end
    endtask : chk_res

    task chk_val(input logic [63:0] g, input logic [63:0] e, input string what);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, g, e);
        end
    endtask : chk_val

    // Issue stays high so that calls run back to back; a stall drops it
    task run(input logic [31:0] w, input logic [XLEN-1:0] a, b, c);
        int n;
        instr = w;
        src_a = a;
        src_b = b;
        src_c = c;
        issue = 1'b1;
        repeat (JUMP_BUFFERED_CYCLES) @(negedge clk_sys);
        if (ready !== 1'b1) begin
            issue = 1'b0;
            got = result;
            chk_res('0, "stall");
            n = 0;
            while (ready !== 1'b1 && n < 20) begin
                @(negedge clk_sys);
                n++;
            end
        end
        got = result;
    endtask : run

    function automatic logic holds(logic [2:0] cd, logic [XLEN-1:0] v);
        logic t;
        t = (cd[1:0] == 2'h0) ? (v == '0) : (cd[1:0] == 2'h2) ? v[63] : !v[0];
        return cd[2] ? !t : t;
    endfunction : holds

    task do_jmp(input logic [2:0] cd, input logic [5:0] r1, input logic [XLEN-1:0] tgt, cv,
        input logic [2:0] ex);
        run({REGISTER_BRANCH_OPCODE, ex[2:1], cd, ex[0], 6'h05, 6'h06, r1}, '0, tgt, cv);
        exp = '0;
        if (cd[1:0] == 2'h1) exp.invalid = 1'b1;
        else if (holds(cd, cv)) begin
            if (tgt[1:0] != 2'h0) exp.align_fault = 1'b1;
            else if (tgt >= 64'h0000_0000_0001_0000) exp.page_fault = 1'b1;
            else begin
                exp.pc_we = 1'b1;
                exp.pc_next = tgt;
                exp.reg_we = r1 != 6'h00;
                exp.reg_idx = r1;
                exp.reg_data = pc + 64'h4;
            end
        end
        chk_res(exp, "jump");
    endtask : do_jmp

    task do_sc(input logic trap, input logic [15:0] imm, input logic [15:0] lim);
        service_limit = lim;
        run({SUPERVISOR_CALL_OPCODE, trap, 1'b0, imm, 6'h03}, '0, '0, '0);
        exp = '0;
        exp.supervisor = 1'b1;
        exp.reg_we = 1'b1;
        exp.reg_idx = 6'h03;
        exp.service_addr = service_base + {42'h0, imm, 6'h00};
        exp.service_trap = imm > lim;
        exp.pc_we = !exp.service_trap;
        exp.pc_next = exp.service_addr;
        exp.slice_end = trap;
        chk_res(exp, "call");
    endtask : do_sc

    initial begin
        repeat (20) @(negedge clk_sys);
        reset_n = 1'b1;
        got = result;
        chk_res('0, "reset");
        chk_val({63'h0, ready}, 64'h1, "ready");
        run({NO_OPERATION_OPCODE, 24'h00_0000}, '0, '0, '0);
        exp = '0;
        exp.nop_done = 1'b1;
        chk_res(exp, "nop");
        run({8'hEE, 24'h00_0000}, '0, '0, '0);
        chk_res('0, "unknown");
        for (int cd = 0; cd < 8; cd++) begin
            for (int v = 0; v < 4; v++) do_jmp(cd[2:0], 6'h07, 64'h100, vals[v], 3'h0);
        end
        do_jmp(3'h0, 6'h07, 64'h0000_0000_0002_0002, '0, 3'h0);
        do_jmp(3'h0, 6'h07, 64'h0000_0000_0002_0000, '0, 3'h0);
        do_jmp(3'h0, 6'h00, 64'h200, '0, 3'h0);
        // Condition operand field zero: taken even though the operand is odd and nonzero
        run({REGISTER_BRANCH_OPCODE, 12'h000, 6'h06, 6'h07}, '0, 64'h600, 64'h3);
        exp = '0;
        exp.pc_we = 1'b1;
        exp.pc_next = 64'h600;
        exp.reg_we = 1'b1;
        exp.reg_idx = 6'h07;
        exp.reg_data = pc + 64'h4;
        chk_res(exp, "always");
        do_jmp(3'h0, 6'h07, 64'h300, '0, 3'h7);
        slow = 1'b1;
        do_jmp(3'h0, 6'h07, 64'h400, '0, 3'h0);
        slow = 1'b0;
        exp = '0;
        exp.reg_we = 1'b1;
        exp.reg_idx = 6'h09;
        exp.reg_data = pc + 64'h4;
        run({RELATIVE_ADDRESS_LOAD_OPCODE, 18'h0_0000, 6'h09}, '0, '0, '0);
        chk_res(exp, "entry");
        pc = 64'h0000_0000_0000_FFFC;
        exp.reg_data = pc + 64'h4;
        exp.page_fault = 1'b1;
        run({RELATIVE_ADDRESS_LOAD_OPCODE, 18'h0_0000, 6'h09}, '0, '0, '0);
        chk_res(exp, "entry miss");
        exp = '0;
        exp.invalid = 1'b1;
        run({RELATIVE_ADDRESS_LOAD_OPCODE, 1'b1, 17'h0_0000, 6'h09}, '0, '0, '0);
        chk_res(exp, "entry data");
        pc = 64'h0000_0000_0000_1000;
        cnt = 64'h3;
        iters = 0;
        do begin
            run({COUNTDOWN_BRANCH_OPCODE, 12'h000, 6'h08, 6'h04}, cnt, 64'h500, '0);
            exp = '0;
            exp.reg_we = 1'b1;
            exp.reg_idx = 6'h04;
            exp.reg_data = cnt - 64'h1;
            exp.pc_we = cnt != '0;
            exp.pc_next = 64'h500;
            chk_res(exp, "loop");
            iters++;
            cnt = cnt - 64'h1;
        end while (got.pc_we === 1'b1 && iters < 8);
        chk_val(64'(iters), 64'h4, "iterations");
        chk_val(got.reg_data, 64'hFFFF_FFFF_FFFF_FFFF, "final count");
        do_sc(1'b0, 16'h0010, 16'h0010);
        do_sc(1'b0, 16'h0011, 16'h0010);
        do_sc(1'b1, 16'hFFFF, 16'hFFFF);
        issue = 1'b0;
        @(negedge clk_sys);
        give_verdict();
    end
endmodule : test_branch_loop_syscall_control
`default_nettype wire
